// ---- rtl/pci_bridge_vga_decode_ordering.sv ----
// forwarding core of a two-port bridge: legacy graphics decode plus
// per-direction posted, delayed request and completion queues.
// assumes both bus front ends run on mclk; range_hit comes from the
// base/limit decoders outside; index 0 is downstream, index 1 upstream.
//
// Overview of operation
// - compatibility mode forwards legacy graphics memory and io downstream
// - frame buffer window spans 000A0000h to 000BFFFFh inclusive
// - compatibility mode ignores secondary masters hitting legacy locations
// - frame buffer reads take one data phase, byte enables unchanged
// - io decode matches low ten bits 3B0h-3BBh or 3C0h-3DFh
// - io bits 15:10 ignored, bits 31:16 must be zero
// - bios region at C0000h only follows ordinary range decode
// - palette snoop forwards io writes to 3C6h, 3C8h, 3C9h with same aliasing
// - palette writes are claimed on the primary bus
// - both mode bits set behaves as compatibility mode alone
// - memory writes are posted and completed once buffered
// - io and config writes get retry and queue as delayed requests
// - all reads get retry and queue as delayed read requests
// - delayed results are buffered and returned in opposite direction
// - writes are never combined, merged or collapsed
// - ordering fixed only at non-retry termination
// - posted writes flow both directions at once, unordered between them
// - posted acceptance never waits on delayed traffic
// - posted keep order; delayed requests wait for older posted writes
// - read completions wait for older posted; write completions need not
// - fair arbitration gives posted writes chances ahead of delayed
module pci_bridge_vga_decode_ordering #(
   parameter int QD = 4
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      clk_en,
   input  wire logic                      vga_mode,
   input  wire logic                      vga_snoop,
   input  wire logic [1:0]                in_valid,
   input  wire bridge_pkg::txn_t [1:0]    in_txn,
   input  wire logic [1:0]                range_hit,
   input  wire logic [1:0]                out_ready,
   input  wire logic [1:0][31:0]          out_rdata,
   output wire bridge_pkg::resp_t [1:0]   resp,
   output wire logic [1:0]                out_valid,
   output wire bridge_pkg::out_t [1:0]    out_txn
);
   import bridge_pkg::*;

   // =======================================================================
   // state
   localparam int PW = $clog2(QD);
   typedef logic [PW:0] ptr_t;
   localparam ptr_t QD_P = ptr_t'(QD);

   typedef struct packed {
      ent_t [1:0][QD-1:0]        pw;
      ent_t [1:0][QD-1:0]        rq;
      ent_t [1:0][QD-1:0]        cp;
      ptr_t [1:0]                pw_wr;
      ptr_t [1:0]                pw_rd;
      ptr_t [1:0]                rq_wr;
      ptr_t [1:0]                rq_rd;
      ptr_t [1:0]                cp_wr;
      ptr_t [1:0]                cp_rd;
      logic [1:0][STAMP_W-1:0]   pw_in;
      logic [1:0][STAMP_W-1:0]   pw_done;
      kind_t [1:0]               last;
      resp_t [1:0]               resp;
      logic [1:0]                out_valid;
      out_t [1:0]                out;
   } st_t;

   localparam st_t ST_RESET = '0;

   st_t s;
   st_t next_s;

   function automatic logic q_full(input ptr_t wr, input ptr_t rd);
      return ptr_t'(wr - rd) == QD_P;
   endfunction : q_full

   function automatic logic q_empty(input ptr_t wr, input ptr_t rd);
      return wr == rd;
   endfunction : q_empty

   // duplicate check: a repeated retried request must not queue twice
   function automatic logic rq_dup(input ent_t [QD-1:0] q, input ptr_t wr,
                                   input ptr_t rd, input txn_t t);
      ptr_t i;
      logic r;
      r = 1'b0;
      i = rd;
      for (int k = 0; k < QD; k++) begin
         if ((i != wr) && (q[i[PW-1:0]].t == t)) begin
            r = 1'b1;
         end
         if (i != wr) begin
            i = ptr_t'(i + 1'b1);
         end
      end
      return r;
   endfunction : rq_dup

   // claim decode; bios space gets no legacy decode, only range_hit
   function automatic logic claim_of(input int d, input txn_t t,
                                     input logic hit);
      if (d == DIR_DOWN) begin
         // legacy io aliases every 1KB below 64KB
         if (vga_mode) begin
            return vga_hit(t) || hit;
         end
         return (vga_snoop && palette_hit(t)) || hit;
      end
      return hit && !(vga_mode && vga_hit(t));
   endfunction : claim_of

   // round robin over posted, request and completion heads
   function automatic kind_t pick(input kind_t last, input logic [2:0] el);
      kind_t c;
      kind_t r;
      r = K_NONE;
      c = (last == K_NONE) ? K_DCPL : last;
      for (int j = 0; j < 3; j++) begin
         c = (c == K_DCPL) ? K_POSTED : kind_t'(c + 1'b1);
         if ((r == K_NONE) && el[c]) begin
            r = c;
         end
      end
      return r;
   endfunction : pick

   // all posted writes older than the stamp have retired; newer writes
   // may pass a waiting entry, so distances back from the input count
   // are compared rather than the stamp against the retire count
   function automatic logic older_done(input logic [STAMP_W-1:0] stamp,
                                       input logic [STAMP_W-1:0] wr_in,
                                       input logic [STAMP_W-1:0] wr_done);
      return STAMP_W'(wr_in - wr_done) <= STAMP_W'(wr_in - stamp);
   endfunction : older_done

   // =======================================================================
   // next state
   always_comb begin : next_logic
      int   o;
      ent_t e;
      logic [2:0] el;
      kind_t pk;
      o = 0;
      e = '0;
      el = '0;
      pk = K_NONE;
      next_s = s;
      next_s.resp = '0;
      // target bus terminations retire the output slot
      for (int d = 0; d < 2; d++) begin
         o = 1 - d;
         if (s.out_valid[d] && out_ready[d]) begin
            next_s.out_valid[d] = 1'b0;
            if (s.out[d].kind == K_POSTED) begin
               next_s.pw_done[d] = STAMP_W'(s.pw_done[d] + 1'b1);
            end
            if (s.out[d].kind == K_DREQ) begin
               // result returns opposite to the request
               e.t = s.out[d].t;
               e.is_read = s.out[d].is_read;
               e.stamp = s.pw_in[o];
               if (s.out[d].is_read) begin
                  e.t.data = out_rdata[d];
               end
               next_s.cp[o][s.cp_wr[o][PW-1:0]] = e;
               next_s.cp_wr[o] = ptr_t'(s.cp_wr[o] + 1'b1);
            end
         end
      end
      // initiator side: each direction accepts on its own
      for (int d = 0; d < 2; d++) begin
         if (in_valid[d] && claim_of(d, in_txn[d], range_hit[d])) begin
            next_s.resp[d].claim = 1'b1;
            e.t = in_txn[d];
            e.is_read = is_read(in_txn[d].cmd);
            e.stamp = s.pw_in[d];
            if (is_posted(in_txn[d].cmd)) begin
               // each write its own entry, no merging
               if (!q_full(s.pw_wr[d], s.pw_rd[d])) begin
                  next_s.pw[d][s.pw_wr[d][PW-1:0]] = e;
                  next_s.pw_wr[d] = ptr_t'(s.pw_wr[d] + 1'b1);
                  next_s.pw_in[d] = STAMP_W'(s.pw_in[d] + 1'b1);
                  next_s.resp[d].posted = 1'b1;
               end else begin
                  next_s.resp[d].retry = 1'b1;
               end
            end else begin
               // order fixed only when later completed
               next_s.resp[d].retry = 1'b1;
               if (!q_full(s.rq_wr[d], s.rq_rd[d]) &&
                   !rq_dup(s.rq[d], s.rq_wr[d], s.rq_rd[d], in_txn[d])) begin
                  next_s.rq[d][s.rq_wr[d][PW-1:0]] = e;
                  next_s.rq_wr[d] = ptr_t'(s.rq_wr[d] + 1'b1);
               end
            end
         end
      end
      // load a free output slot from the eligible heads
      for (int d = 0; d < 2; d++) begin
         o = 1 - d;
         el[K_POSTED] = !q_empty(s.pw_wr[d], s.pw_rd[d]);
         // requests wait for older posted, and for room to return
         el[K_DREQ] = !q_empty(s.rq_wr[d], s.rq_rd[d]) &&
            older_done(s.rq[d][s.rq_rd[d][PW-1:0]].stamp, s.pw_in[d],
                       s.pw_done[d]) &&
            !q_full(s.cp_wr[o], s.cp_rd[o]);
         el[K_DCPL] = !q_empty(s.cp_wr[d], s.cp_rd[d]) &&
            (!s.cp[d][s.cp_rd[d][PW-1:0]].is_read ||
             older_done(s.cp[d][s.cp_rd[d][PW-1:0]].stamp, s.pw_in[d],
                        s.pw_done[d]));
         pk = pick(s.last[d], el);
         if (!s.out_valid[d] && (pk != K_NONE)) begin
            case (pk)
               K_POSTED: begin
                  e = s.pw[d][s.pw_rd[d][PW-1:0]];
                  next_s.pw_rd[d] = ptr_t'(s.pw_rd[d] + 1'b1);
               end
               K_DREQ: begin
                  e = s.rq[d][s.rq_rd[d][PW-1:0]];
                  next_s.rq_rd[d] = ptr_t'(s.rq_rd[d] + 1'b1);
               end
               default: begin
                  e = s.cp[d][s.cp_rd[d][PW-1:0]];
                  next_s.cp_rd[d] = ptr_t'(s.cp_rd[d] + 1'b1);
               end
            endcase
            next_s.last[d] = pk;
            next_s.out_valid[d] = 1'b1;
            next_s.out[d].kind = pk;
            next_s.out[d].t = e.t;  // byte enables untouched
            next_s.out[d].is_read = e.is_read;
            next_s.out[d].stamp = e.stamp;
            next_s.out[d].single = (e.t.cmd == CMD_MEM_RD) ||
               (e.is_read && fb_hit(e.t));
         end
      end
   end

   // state register; clk_en low freezes everything
   always_ff @(posedge mclk or posedge reset) begin : state_reg
      if (reset) begin
         s <= ST_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign resp      = s.resp;
   assign out_valid = s.out_valid;
   assign out_txn   = s.out;

   // =======================================================================
   // checks
   property p_vga_down;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[0] && vga_mode && vga_hit(in_txn[0])
      |=> resp[0].claim;
   endproperty
   a_vga_down: assert property (p_vga_down)
      else $error("legacy graphics access not claimed downstream");

   property p_vga_up;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[1] && vga_mode && vga_hit(in_txn[1])
      |=> !resp[1].claim;
   endproperty
   a_vga_up: assert property (p_vga_up)
      else $error("legacy graphics access claimed upstream");

   property p_snoop;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[0] && vga_snoop && palette_hit(in_txn[0])
      |=> resp[0].claim && !resp[0].posted;
   endproperty
   a_snoop: assert property (p_snoop)
      else $error("palette write not claimed");

   property p_posted;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[0] && resp[0] == '0 &&
      claim_of(DIR_DOWN, in_txn[0], range_hit[0]) &&
      is_posted(in_txn[0].cmd) && !q_full(s.pw_wr[0], s.pw_rd[0])
      |=> resp[0].posted && !resp[0].retry;
   endproperty
   a_posted: assert property (p_posted)
      else $error("posted write not accepted with room free");

   property p_posted_up;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[1] && is_posted(in_txn[1].cmd) &&
      claim_of(DIR_UP, in_txn[1], range_hit[1]) &&
      !q_full(s.pw_wr[1], s.pw_rd[1])
      |=> resp[1].posted && !resp[1].retry;
   endproperty
   a_posted_up: assert property (p_posted_up)
      else $error("upstream posted write not accepted with room free");

   property p_delayed;
      @(posedge mclk) disable iff (reset)
      clk_en && in_valid[1] && !is_posted(in_txn[1].cmd) &&
      claim_of(DIR_UP, in_txn[1], range_hit[1])
      |=> resp[1].retry && !resp[1].posted;
   endproperty
   a_delayed: assert property (p_delayed)
      else $error("delayed transaction not retried");

   property p_req_order;
      @(posedge mclk) disable iff (reset)
      $rose(out_valid[0]) && out_txn[0].kind == K_DREQ
      |-> older_done(out_txn[0].stamp, s.pw_in[0], s.pw_done[0]);
   endproperty
   a_req_order: assert property (p_req_order)
      else $error("delayed request passed an older posted write");

   property p_cpl_order;
      @(posedge mclk) disable iff (reset)
      $rose(out_valid[1]) && out_txn[1].kind == K_DCPL &&
      out_txn[1].is_read
      |-> older_done(out_txn[1].stamp, s.pw_in[1], s.pw_done[1]);
   endproperty
   a_cpl_order: assert property (p_cpl_order)
      else $error("read completion passed an older posted write");

   property p_single;
      @(posedge mclk) disable iff (reset)
      out_valid[0] && out_txn[0].is_read && fb_hit(out_txn[0].t)
      |-> out_txn[0].single;
   endproperty
   a_single: assert property (p_single)
      else $error("frame buffer read not limited to one data phase");

   property p_return;
      @(posedge mclk) disable iff (reset)
      clk_en && out_valid[0] && out_ready[0] && out_txn[0].kind == K_DREQ
      |=> s.cp_wr[1] == ptr_t'($past(s.cp_wr[1]) + 1'b1);
   endproperty
   a_return: assert property (p_return)
      else $error("delayed result not queued for return");

   c_posted: cover property (@(posedge mclk) disable iff (reset)
      resp[0].posted);
   c_retry: cover property (@(posedge mclk) disable iff (reset)
      resp[1].retry);
   c_cpl: cover property (@(posedge mclk) disable iff (reset)
      out_valid[1] && out_txn[1].kind == K_DCPL);
   c_snoop: cover property (@(posedge mclk) disable iff (reset)
      clk_en && in_valid[0] && vga_snoop && palette_hit(in_txn[0]));

endmodule : pci_bridge_vga_decode_ordering

// ---- rtl/bridge_pkg.sv ----
// ==========================================================================
// package for the bridge forwarding core: bus commands, legacy graphics
// decode windows, transaction carriers and small decode functions.
// assumes pci command encodings arrive unchanged from the bus front ends.
// ==========================================================================
package bridge_pkg;

   // =======================================================================
   // bus command codes
   localparam logic [3:0] CMD_IO_RD   = 4'h2;
   localparam logic [3:0] CMD_IO_WR   = 4'h3;
   localparam logic [3:0] CMD_MEM_RD  = 4'h6;
   localparam logic [3:0] CMD_MEM_WR  = 4'h7;
   localparam logic [3:0] CMD_CFG_RD  = 4'hA;
   localparam logic [3:0] CMD_CFG_WR  = 4'hB;
   localparam logic [3:0] CMD_MEM_RDM = 4'hC;
   localparam logic [3:0] CMD_MEM_RDL = 4'hE;
   localparam logic [3:0] CMD_MWI     = 4'hF;

   // =======================================================================
   // legacy graphics decode windows
   localparam logic [31:0] FB_LO      = 32'h000A_0000;
   localparam logic [31:0] FB_HI      = 32'h000B_FFFF;
   localparam int          IO_HI_LSB  = 16;
   localparam int          IO_ALIAS_W = 10;
   localparam logic [9:0]  IO_A_LO    = 10'h3B0;
   localparam logic [9:0]  IO_A_HI    = 10'h3BB;
   localparam logic [9:0]  IO_B_LO    = 10'h3C0;
   localparam logic [9:0]  IO_B_HI    = 10'h3DF;
   localparam logic [9:0]  PAL_MASK   = 10'h3C6;
   localparam logic [9:0]  PAL_WADDR  = 10'h3C8;
   localparam logic [9:0]  PAL_DATA   = 10'h3C9;

   // =======================================================================
   // ordering stamps and directions
   localparam int STAMP_W  = 3;
   localparam int DIR_DOWN = 0;
   localparam int DIR_UP   = 1;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } txn_t;

   typedef enum logic [1:0] {
      K_POSTED = 2'b00,
      K_DREQ   = 2'b01,
      K_DCPL   = 2'b10,
      K_NONE   = 2'b11
   } kind_t;

   typedef struct packed {
      txn_t               t;
      logic [STAMP_W-1:0] stamp;
      logic               is_read;
   } ent_t;

   typedef struct packed {
      logic claim;
      logic posted;
      logic retry;
   } resp_t;

   typedef struct packed {
      kind_t              kind;
      txn_t               t;
      logic               single;
      logic               is_read;
      logic [STAMP_W-1:0] stamp;
   } out_t;

   function automatic logic is_posted(input logic [3:0] c);
      return (c == CMD_MEM_WR) || (c == CMD_MWI);
   endfunction : is_posted

   function automatic logic is_read(input logic [3:0] c);
      return (c == CMD_IO_RD) || (c == CMD_MEM_RD) || (c == CMD_CFG_RD) ||
             (c == CMD_MEM_RDM) || (c == CMD_MEM_RDL);
   endfunction : is_read

   function automatic logic is_mem(input logic [3:0] c);
      return (c == CMD_MEM_RD) || (c == CMD_MEM_WR) || (c == CMD_MEM_RDM) ||
             (c == CMD_MEM_RDL) || (c == CMD_MWI);
   endfunction : is_mem

   function automatic logic fb_hit(input txn_t t);
      return is_mem(t.cmd) && (t.addr >= FB_LO) && (t.addr <= FB_HI);
   endfunction : fb_hit

   // io aliases every 1KB below 64KB: upper half zero, middle bits ignored
   function automatic logic io_low(input txn_t t);
      return ((t.cmd == CMD_IO_RD) || (t.cmd == CMD_IO_WR)) &&
             ((t.addr >> IO_HI_LSB) == 32'h0000_0000);
   endfunction : io_low

   function automatic logic vga_hit(input txn_t t);
      logic [9:0] a;
      a = t.addr[IO_ALIAS_W-1:0];
      return fb_hit(t) || (io_low(t) &&
             (((a >= IO_A_LO) && (a <= IO_A_HI)) ||
              ((a >= IO_B_LO) && (a <= IO_B_HI))));
   endfunction : vga_hit

   function automatic logic palette_hit(input txn_t t);
      logic [9:0] a;
      a = t.addr[IO_ALIAS_W-1:0];
      return io_low(t) && (t.cmd == CMD_IO_WR) &&
             ((a == PAL_MASK) || (a == PAL_WADDR) || (a == PAL_DATA));
   endfunction : palette_hit

endpackage : bridge_pkg

// ---- dv/bridge_target_model.sv ----
// ==========================================
// far-side target model for both directions.
// assumes out_valid holds until out_ready; drives on falling mclk.
module bridge_target_model (
   input  wire logic                  mclk,
   input  wire logic                  slow,
   input  wire logic [1:0]            out_valid,
   input  wire bridge_pkg::out_t [1:0] out_txn,
   output logic [1:0]                 out_ready,
   output logic [1:0][31:0]           out_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import bridge_pkg::*;

   logic [1:0][2:0] wait_cnt;

   initial begin
      out_ready = 2'b00;
      out_rdata = '0;
      wait_cnt = '0;
   end

   // ==========================================
   // answer promptly, or after three stalled cycles so queues back up
   always @(negedge mclk) begin
      for (int d = 0; d < 2; d++) begin
         if (out_valid[d] && !out_ready[d] &&
             (!slow || wait_cnt[d] == 3'h3)) begin
            out_ready[d] <= 1'b1;
            out_rdata[d] <= ~out_txn[d].t.addr;
            wait_cnt[d] <= 3'h0;
         end else begin
            out_ready[d] <= 1'b0;
            // idle data keeps toggling so a stale word never looks valid
            out_rdata[d] <= ~out_rdata[d];
            if (out_valid[d] && !out_ready[d])
               wait_cnt[d] <= wait_cnt[d] + 3'h1;
         end
      end
   end
endmodule : bridge_target_model

// ---- dv/tb_pci_bridge_vga_decode_ordering.sv ----
// ==========================================
// self-checking bench for the bridge forwarding core.
// assumes the target model completes every presented transfer.
module tb_pci_bridge_vga_decode_ordering;
   timeunit 1ns;
   timeprecision 1ns;
   import bridge_pkg::*;

   logic             mclk = 1'b0;
   logic             reset = 1'b1;
   logic             clk_en = 1'b1;
   logic             vga_mode = 1'b0;
   logic             vga_snoop = 1'b0;
   logic             slow = 1'b0;
   logic [1:0]       in_valid = 2'b00;
   txn_t [1:0]       in_txn = '0;
   logic [1:0]       range_hit = 2'b00;
   logic [1:0]       out_ready;
   logic [1:0][31:0] out_rdata;
   resp_t [1:0]      resp;
   logic [1:0]       out_valid;
   out_t [1:0]       out_txn;
   out_t             lg[2][$];
   int               errors = 0;
   int               n_checks = 0;

   always #50 mclk = ~mclk;

   pci_bridge_vga_decode_ordering #(.QD(4)) dut (
      .mclk(mclk), .reset(reset), .clk_en(clk_en),
      .vga_mode(vga_mode), .vga_snoop(vga_snoop),
      .in_valid(in_valid), .in_txn(in_txn), .range_hit(range_hit),
      .out_ready(out_ready), .out_rdata(out_rdata), .resp(resp),
      .out_valid(out_valid), .out_txn(out_txn));

   bridge_target_model far (
      .mclk(mclk), .slow(slow), .out_valid(out_valid),
      .out_txn(out_txn), .out_ready(out_ready), .out_rdata(out_rdata));

   // ==========================================
   // log each completed far-side transfer, pre-edge values
   always @(posedge mclk) begin
      for (int d = 0; d < 2; d++) begin
         if (out_valid[d] && out_ready[d] && clk_en)
            lg[d].push_back(out_txn[d]);
      end
   end

   task automatic conclude();
      if (errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk_val(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk_val

   // one attempt on bus d; the answer stands in the following cycle
   task automatic ask(input int d, input logic [3:0] c,
                      input logic [31:0] a, input logic hit);
      logic [2:0] e;
      e = !hit ? 3'h0 : (c == CMD_MEM_WR || c == CMD_MWI) ? 3'h6 : 3'h5;
      @(negedge mclk);
      in_txn[d] = '{c, a, 4'h6, ~a};
      in_valid[d] = 1'b1;
      @(negedge mclk);
      in_valid[d] = 1'b0;
      chk_val("resp", 32'(e), 32'(resp[d]));
   endtask : ask

   // bounded wait for both far ports to stay idle, then clear the logs
   task automatic clr();
      int quiet;
      quiet = 0;
      for (int i = 0; i < 500 && quiet < 8; i++) begin
         @(negedge mclk);
         quiet = (out_valid == 2'b00) ? quiet + 1 : 0;
      end
      if (quiet < 8) begin
         errors++;
         $display("unexpected drain: expected idle seen busy");
         conclude();
      end
      lg[0].delete();
      lg[1].delete();
   endtask : clr

   // ==========================================
   // window edges, io aliasing and palette snoop on the primary side
   task automatic s_decode();
      vga_mode = 1'b1;
      ask(0, CMD_MEM_RD, FB_LO - 32'h1, 0);
      ask(0, CMD_MEM_RD, FB_LO, 1);
      ask(0, CMD_MEM_RDM, FB_HI, 1);
      ask(0, CMD_MEM_RD, FB_HI + 32'h1, 0);
      ask(0, CMD_MEM_RD, 32'h000C_0000, 0);
      ask(0, CMD_MEM_WR, 32'h000A_8000, 1);
      ask(0, CMD_IO_RD, 32'h0000_FBAF, 0);
      ask(0, CMD_IO_RD, 32'h0000_7FB0, 1);
      ask(0, CMD_IO_RD, 32'h0000_03BB, 1);
      ask(0, CMD_IO_RD, 32'h0000_03BC, 0);
      ask(0, CMD_IO_WR, 32'h0000_03C0, 1);
      ask(0, CMD_IO_RD, 32'h0000_FFDF, 1);
      ask(0, CMD_IO_RD, 32'h0000_03E0, 0);
      ask(0, CMD_IO_RD, 32'h0001_03C0, 0);
      vga_snoop = 1'b1;
      ask(0, CMD_IO_WR, 32'h0000_03C7, 1);
      vga_mode = 1'b0;
      ask(0, CMD_IO_WR, 32'h0000_03C7, 0);
      ask(0, CMD_IO_WR, 32'h0000_07C6, 1);
      ask(0, CMD_IO_WR, 32'h0000_FFC8, 1);
      ask(0, CMD_IO_WR, 32'h0000_03C9, 1);
      ask(0, CMD_IO_RD, 32'h0000_03C8, 0);
      ask(0, CMD_IO_WR, 32'h0002_03C9, 0);
      vga_snoop = 1'b0;
      clr();
   endtask : s_decode

   // secondary masters aimed at legacy locations
   task automatic s_up();
      vga_mode = 1'b1;
      range_hit = 2'b10;
      ask(1, CMD_MEM_WR, 32'h000A_0000, 0);
      ask(1, CMD_IO_RD, 32'h0000_03B4, 0);
      ask(1, CMD_MEM_WR, 32'h0010_0000, 1);
      // a low enable must hold the one-cycle answer past the next edge
      clk_en = 1'b0;
      @(negedge mclk);
      chk_val("frozen resp", 32'h6, 32'(resp[1]));
      clk_en = 1'b1;
      ask(1, CMD_MWI, 32'h0010_0040, 1);
      ask(1, CMD_CFG_WR, 32'h0000_0800, 1);
      ask(1, CMD_CFG_RD, 32'h0000_0804, 1);
      vga_mode = 1'b0;
      ask(1, CMD_MEM_WR, 32'h000A_0000, 1);
      clr();
   endtask : s_up

   // frame buffer read goes out single, completion comes back upstream
   task automatic s_fbread();
      vga_mode = 1'b1;
      range_hit = 2'b00;
      ask(0, CMD_MEM_RDL, 32'h000B_0010, 1);
      clr_keep();
   endtask : s_fbread

   task automatic clr_keep();
      for (int i = 0; i < 60; i++) begin
         @(negedge mclk);
      end
      chk_val("req kind", 32'(K_DREQ), 32'(lg[0][0].kind));
      chk_val("single", 32'h1, 32'(lg[0][0].single));
      chk_val("be", 32'h6, 32'(lg[0][0].t.be));
      chk_val("cpl kind", 32'(K_DCPL), 32'(lg[1][0].kind));
      chk_val("cpl data", 32'hFFF4_FFEF, lg[1][0].t.data);
      clr();
   endtask : clr_keep

   // posted writes both ways at once behind a stalled delayed write
   task automatic s_posted();
      int j;
      int c;
      vga_mode = 1'b0;
      range_hit = 2'b11;
      slow = 1'b1;
      ask(0, CMD_IO_WR, 32'h0000_1000, 1);
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         if (i > 0) begin
            chk_val("resp0", 32'h6, 32'(resp[0]));
            chk_val("resp1", 32'h6, 32'(resp[1]));
         end
         for (int d = 0; d < 2; d++)
            in_txn[d] = '{CMD_MEM_WR, 32'h0040_0000, 4'(1 << i),
                          32'(i + 4 * d)};
         in_valid = (i < 3) ? 2'b11 : 2'b00;
      end
      ask(0, CMD_IO_WR, 32'h0000_1000, 1);
      for (int i = 0; i < 80; i++) begin
         @(negedge mclk);
      end
      c = 0;
      for (int d = 0; d < 2; d++) begin
         j = 0;
         for (int k = 0; k < lg[d].size(); k++) begin
            if (lg[d][k].kind === K_DCPL)
               c++;
            if (lg[d][k].kind === K_POSTED) begin
               chk_val("wr be", 32'(1 << j), 32'(lg[d][k].t.be));
               chk_val("wr data", 32'(j + 4 * d), lg[d][k].t.data);
               j++;
            end
         end
         chk_val("wr count", 32'h3, 32'(j));
      end
      chk_val("wr cpl", 32'h1, 32'(c > 0));
      clr();
   endtask : s_posted

   // a read behind older posted writes in both directions
   task automatic s_order();
      for (int i = 0; i < 3; i++)
         ask(1, CMD_MEM_WR, 32'h0050_0000 + 32'(i), 1);
      ask(0, CMD_MEM_WR, 32'h0060_0000, 1);
      ask(0, CMD_MEM_RD, 32'h0060_0000, 1);
      for (int i = 0; i < 80; i++) begin
         @(negedge mclk);
      end
      chk_val("dn first", 32'(K_POSTED), 32'(lg[0][0].kind));
      chk_val("dn next", 32'(K_DREQ), 32'(lg[0][1].kind));
      chk_val("up last", 32'(K_DCPL), 32'(lg[1][3].kind));
      chk_val("up data", 32'hFF9F_FFFF, lg[1][3].t.data);
      clr();
   endtask : s_order

   initial begin
      repeat (4) @(negedge mclk);
      reset = 1'b0;
      s_decode();
      s_up();
      s_fbread();
      s_posted();
      s_order();
      conclude();
   end
endmodule : tb_pci_bridge_vga_decode_ordering
